// ---- i2c_slave_addr_frontend.sv ----
/*
 * Two-wire bus slave front end: start/stop detection, address word decode,
 * acknowledge handling, byte receive and transmit, write protect, APB registers.
 * Assumes an external master drives the serial clock; pad pull-downs present
 * open strap and protect pins as low; APB master on the same clock.
 */
// Functional notes
// - Sample on clock rise, change after fall.
// - Data changes only while clock low.
// - Data falling while clock high is start.
// - Data rising while clock high: stop, standby.
// - Ready immediately after stop, no wait.
// - Receiver pulls data low on ninth clock.
// - Transmitter releases data on ninth clock.
// - Stop before acknowledge abandons, enters standby.
// - After not-acknowledge, release the bus.
// - Address word: type, select, direction.
// - Upper four bits must match type code.
// - Select code must equal strap pins.
// - Open strap pins read as low.
// - Write protect high blocks all writes.
// - Reads always allowed regardless of protect.
// - Open protect pin reads low, writable.
// - Open-drain data: pull low or release.
// - Pure slave, never initiates, waits selection.
// - Select bits sent MSB first, 2-1-0.
// - Last address bit: zero write, one read.
// - Mismatch means standby and no acknowledge.
// - Matching address acknowledged on ninth bit.
`timescale 1ns/1ps
`include "fe_cfg.svh"
module i2c_slave_addr_frontend
    import fe_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = `FE_TYPE_CODE_DEFAULT
) (
    input wire logic clock, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [7:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic sclIn, // Serial clock pin
    input wire logic sdaIn, // Serial data pin level
    output logic sdaOut, // Serial data drive value
    output logic sdaOe, // Serial data pull-down enable
    input wire logic strapSelBit0, // Select strap bit 0
    input wire logic strapSelBit1, // Select strap bit 1
    input wire logic strapSelBit2, // Select strap bit 2
    input wire logic wpIn, // Write protect pin
    output logic [7:0] rxByteOut, // Last accepted write byte
    output logic rxStrobe, // Write byte received
    output logic rxWriteEn // Write byte may be stored
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    pins_s pinsRaw;
    pins_s pins;
    logic prevScl;
    logic prevSda;
    bus_evt_s evt;
    bus_state_e state;
    bus_state_e next_state;
    logic seenRise;
    logic masterAck;
    logic dirRead;
    logic [7:0] addrWord;
    logic [7:0] rxData;
    logic [7:0] txData;
    logic ctrlEnable;
    sticky_s sticky;
    sticky_s stickySet;
    sticky_s stickyClr;
    logic [7:0] rxByte;
    logic txBit;
    logic [3:0] bitCount;

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    // Open pins arrive low through pad pull-downs
    assign pinsRaw = {strapSelBit2, strapSelBit1, strapSelBit0, wpIn, sdaIn, sclIn};

    fe_pin_sync #(
        .WIDTH(6),
        .RESET_VAL(`FE_PIN_RESET)
    ) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .asyncIn(pinsRaw),
        .syncOut(pins)
    );

    // Previous synchronised wire levels for edge finding
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prevScl <= 1'b1;
            prevSda <= 1'b1;
        end else begin
            prevScl <= pins.scl;
            prevSda <= pins.sda;
        end
    end

    // ------------------------------------------------------------------------
    // Bus event decode
    // ------------------------------------------------------------------------
    // Data sampled on clock rise, output moved after fall
    assign evt.rise = pins.scl & ~prevScl;
    assign evt.fall = ~pins.scl & prevScl;
    // Data edge with clock held high marks start or stop
    assign evt.start = pins.scl & prevScl & prevSda & ~pins.sda;
    assign evt.stop = pins.scl & prevScl & ~prevSda & pins.sda;

    // ------------------------------------------------------------------------
    // Group and address decode
    // ------------------------------------------------------------------------
    wire byteDone = (bitCount == `FE_BITS_PER_BYTE) & evt.fall;
    // Type code in upper nibble
    wire typeHit = rxByte[7:4] == TYPE_CODE;
    // Select bits arrive strap 2, 1, 0 in that order
    wire selHit = rxByte[3:1] == pins.strap;
    wire addrHit = typeHit & selHit & ctrlEnable;
    // Direction bit, one requests a read
    wire rwBit = rxByte[0];
    wire inAck = (state == ST_ADDR_ACK) | (state == ST_WR_ACK) | (state == ST_RD_ACK);
    wire ackDone = inAck & seenRise & evt.fall;
    wire shiftIn = evt.rise & ((state == ST_ADDR) | (state == ST_WR_BYTE) | (state == ST_RD_BYTE));
    wire loadTx = ackDone & (((state == ST_ADDR_ACK) & dirRead) | ((state == ST_RD_ACK) & masterAck));
    wire shiftTx = (state == ST_RD_BYTE) & evt.fall & (bitCount != 4'h0) & ~byteDone;
    wire clearCnt = evt.start | ackDone;
    wire wrByteDone = (state == ST_WR_BYTE) & byteDone;

    fe_bit_shifter #(
        .CNT_W(4)
    ) u_shift (
        .clock(clock),
        .rst_b(rst_b),
        .clearCnt(clearCnt),
        .sampleEn(shiftIn),
        .bitIn(pins.sda),
        .loadEn(loadTx),
        .loadByte(txData),
        .shiftEn(shiftTx),
        .rxByte(rxByte),
        .txBit(txBit),
        .bitCount(bitCount)
    );

    // ------------------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------------------
    // Next state; stop and start override every state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                next_state = ST_IDLE; // Only a start leaves standby
            end
            ST_ADDR: begin
                if (byteDone) begin
                    next_state = addrHit ? ST_ADDR_ACK : ST_IDLE;
                end
            end
            ST_ADDR_ACK: begin
                if (ackDone) begin
                    next_state = dirRead ? ST_RD_BYTE : ST_WR_BYTE;
                end
            end
            ST_WR_BYTE: begin
                if (byteDone) begin
                    next_state = ST_WR_ACK;
                end
            end
            ST_WR_ACK: begin
                if (ackDone) begin
                    next_state = ST_WR_BYTE;
                end
            end
            ST_RD_BYTE: begin
                if (byteDone) begin
                    next_state = ST_RD_ACK; // Release for master answer
                end
            end
            ST_RD_ACK: begin
                if (ackDone) begin
                    // Not-acknowledge releases and waits stop or start
                    next_state = masterAck ? ST_RD_BYTE : ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (evt.stop) begin
            next_state = ST_IDLE; // Standby at once, no busy time
        end
        if (evt.start) begin
            next_state = ST_ADDR; // Start or repeated start
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Ninth-clock tracking and master acknowledge capture
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            seenRise <= 1'b0;
            masterAck <= 1'b0;
        end else begin
            seenRise <= inAck & (seenRise | evt.rise) & ~ackDone & ~evt.start & ~evt.stop;
            if ((state == ST_RD_ACK) & evt.rise) begin
                masterAck <= ~pins.sda;
            end
        end
    end

    // Address word capture and direction
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            addrWord <= `FE_BYTE_RESET;
            dirRead <= 1'b0;
        end else if ((state == ST_ADDR) & byteDone) begin
            addrWord <= rxByte;
            dirRead <= rwBit;
        end
    end

    // ------------------------------------------------------------------------
    // Data wire drive
    // ------------------------------------------------------------------------
    // Only ever pulls low, decoded from registers
    assign sdaOut = 1'b0;
    // Acknowledge low on ninth clock, read bits while reading
    assign sdaOe = (state == ST_ADDR_ACK) | (state == ST_WR_ACK) | ((state == ST_RD_BYTE) & ~txBit);

    // ------------------------------------------------------------------------
    // Received write data
    // ------------------------------------------------------------------------
    // Protect high keeps the byte from storage
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rxData <= `FE_BYTE_RESET;
            rxStrobe <= 1'b0;
            rxWriteEn <= 1'b0;
        end else begin
            rxStrobe <= wrByteDone;
            rxWriteEn <= wrByteDone & ~pins.wp;
            if (wrByteDone & ~pins.wp) begin
                rxData <= rxByte;
            end
        end
    end

    assign rxByteOut = rxData;

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire selCtrl = paddr == `FE_OFS_CTRL;
    wire selStatus = paddr == `FE_OFS_STATUS;
    wire selAddr = paddr == `FE_OFS_ADDRWORD;
    wire selRx = paddr == `FE_OFS_RXDATA;
    wire selTx = paddr == `FE_OFS_TXDATA;
    wire mapped = selCtrl | selStatus | selAddr | selRx | selTx;
    wire setupPhase = psel & ~penable;
    wire wrAccess = psel & penable & pwrite & mapped;
    wire [31:0] statusWord = {21'h0, sticky, 3'h0, pins.wp, dirRead, state};
    wire [31:0] readMux = selCtrl ? {31'h0, ctrlEnable} :
                          selStatus ? statusWord :
                          selAddr ? {24'h000000, addrWord} :
                          selRx ? {24'h000000, rxData} :
                          selTx ? {24'h000000, txData} : 32'h00000000;

    // Zero-wait slave; unmapped address answers with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Read data captured in the setup cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (setupPhase) begin
            prdata <= readMux;
        end
    end

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    // Enable steers address acceptance; transmit byte feeds reads
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrlEnable <= `FE_CTRL_RESET;
            txData <= `FE_TX_RESET;
        end else if (wrAccess) begin
            if (selCtrl) begin
                ctrlEnable <= pwdata[`FE_CTRL_EN_BIT];
            end
            if (selTx) begin
                txData <= pwdata[7:0];
            end
        end
    end

    // Sticky flags: write one clears, a new event wins over the clear
    assign stickySet.matched = (state == ST_ADDR) & byteDone & addrHit;
    assign stickySet.blocked = wrByteDone & pins.wp;
    assign stickySet.rxNew = wrByteDone & ~pins.wp;
    assign stickyClr = (wrAccess & selStatus) ? pwdata[`FE_ST_STICKY_LSB +: 3] : 3'h0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sticky <= 3'h0;
        end else begin
            sticky <= (sticky & ~stickyClr) | stickySet;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_drive_only_low: assert property (@(posedge clock) disable iff (!rst_b)
        sdaOut == 1'b0)
        else $error("data wire driven high");

    a_idle_stays_quiet: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ST_IDLE) |-> !sdaOe)
        else $error("data driven while in standby");

    a_stop_to_idle: assert property (@(posedge clock) disable iff (!rst_b)
        (evt.stop && !evt.start) |=> (state == ST_IDLE) && !sdaOe)
        else $error("stop did not return to standby");

    a_start_to_addr: assert property (@(posedge clock) disable iff (!rst_b)
        evt.start |=> (state == ST_ADDR) && (bitCount == 4'h0))
        else $error("start did not open address reception");

    a_oe_after_fall: assert property (@(posedge clock) disable iff (!rst_b)
        $changed(sdaOe) |-> ($past(evt.fall) || $past(evt.start) || $past(evt.stop)))
        else $error("data drive moved without clock fall");

    a_mismatch_no_ack: assert property (@(posedge clock) disable iff (!rst_b)
        ((state == ST_ADDR) && byteDone && !addrHit && !evt.start) |=> (state == ST_IDLE) [*2])
        else $error("mismatched address not dropped");

    a_match_acks: assert property (@(posedge clock) disable iff (!rst_b)
        ((state == ST_ADDR) && byteDone && addrHit) |=> sdaOe && (state == ST_ADDR_ACK))
        else $error("matching address not acknowledged");

    a_nack_release: assert property (@(posedge clock) disable iff (!rst_b)
        ((state == ST_RD_ACK) && ackDone && !masterAck && !evt.start) |=> !sdaOe && (state == ST_IDLE))
        else $error("bus not released after not-acknowledge");

    a_read_ack_free: assert property (@(posedge clock) disable iff (!rst_b)
        (state == ST_RD_ACK) |-> !sdaOe)
        else $error("transmitter held data on ninth clock");

    a_wp_blocks_write: assert property (@(posedge clock) disable iff (!rst_b)
        (wrByteDone && pins.wp) |=> !rxWriteEn && $stable(rxData) && sticky.blocked)
        else $error("protected write was accepted");

    a_write_ack_next: assert property (@(posedge clock) disable iff (!rst_b)
        (wrByteDone && !evt.start && !evt.stop) |=> sdaOe ##1 1'b1)
        else $error("received byte not acknowledged");

    a_read_ignores_wp: assert property (@(posedge clock) disable iff (!rst_b)
        ((state == ST_ADDR_ACK) && ackDone && dirRead && !evt.start && !evt.stop) |=> (state == ST_RD_BYTE))
        else $error("read refused");

endmodule : i2c_slave_addr_frontend

// ---- fe_cfg.svh ----
/*
 * Constants of the two-wire slave front end: register offsets, field positions,
 * reset values and bit counts.
 * Assumes it is included by its bare name from every design file that needs it.
 */
`ifndef FE_CFG_SVH
`define FE_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define FE_OFS_CTRL 8'h00
`define FE_OFS_STATUS 8'h04
`define FE_OFS_ADDRWORD 8'h08
`define FE_OFS_RXDATA 8'h0c
`define FE_OFS_TXDATA 8'h10

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define FE_CTRL_EN_BIT 0
`define FE_CTRL_RESET 1'b1
`define FE_ST_STATE_LSB 0
`define FE_ST_DIR_BIT 3
`define FE_ST_WP_BIT 4
`define FE_ST_STICKY_LSB 8
`define FE_TX_RESET 8'hff
`define FE_BYTE_RESET 8'h00
// Idle bus reads high on both wires, straps and protect low
`define FE_PIN_RESET 6'h03

// ----------------------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------------------
`define FE_BITS_PER_BYTE 4'h8
// Arbitrary neutral device type code
`define FE_TYPE_CODE_DEFAULT 4'h5

`endif

// ---- fe_pkg.sv ----
/*
 * Types shared by the front end: bus states, pin bundle, bus events, sticky flags.
 * Assumes nothing of its surroundings.
 */
package fe_pkg;

    // ------------------------------------------------------------------------
    // Bus sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR_BYTE = 3'b011,
        ST_WR_ACK = 3'b100,
        ST_RD_BYTE = 3'b101,
        ST_RD_ACK = 3'b110
    } bus_state_e;

    // Pins from outside the clock domain
    typedef struct packed {
        logic [2:0] strap;
        logic wp;
        logic sda;
        logic scl;
    } pins_s;

    // Decoded bus events, one-cycle pulses
    typedef struct packed {
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } bus_evt_s;

    // Sticky status flags
    typedef struct packed {
        logic rxNew;
        logic blocked;
        logic matched;
    } sticky_s;

endpackage : fe_pkg

// ---- fe_pin_sync.sv ----
/*
 * Two-flop synchroniser for a bundle of asynchronous pins.
 * Assumes every bit is a level; only the second stage is read outside.
 */
`timescale 1ns/1ps
module fe_pin_sync #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [WIDTH-1:0] asyncIn, // Raw pin levels
    output logic [WIDTH-1:0] syncOut // Synchronised levels
);

    // ------------------------------------------------------------------------
    // One pair of flops per bit
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            // First stage feeds only the second
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    stage1 <= RESET_VAL[i];
                    syncOut[i] <= RESET_VAL[i];
                end else begin
                    stage1 <= asyncIn[i];
                    syncOut[i] <= stage1;
                end
            end
        end
    endgenerate

endmodule : fe_pin_sync

// ---- fe_bit_shifter.sv ----
/*
 * Bit counter with receive and transmit shift registers, MSB first.
 * Assumes strobes are one-cycle pulses on the system clock.
 */
`timescale 1ns/1ps
`include "fe_cfg.svh"
module fe_bit_shifter #(
    parameter int CNT_W = 4
) (
    input wire logic clock, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic clearCnt, // Restart bit count
    input wire logic sampleEn, // Take bitIn, count one
    input wire logic bitIn, // Sampled data bit
    input wire logic loadEn, // Load transmit byte
    input wire logic [7:0] loadByte, // Byte to transmit
    input wire logic shiftEn, // Present next transmit bit
    output logic [7:0] rxByte, // Received byte
    output logic txBit, // Current transmit bit
    output logic [CNT_W-1:0] bitCount // Bits taken since clear
);

    logic [7:0] txShift;

    // Count bits of the current group
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bitCount <= '0;
        end else if (clearCnt) begin
            bitCount <= '0;
        end else if (sampleEn) begin
            bitCount <= CNT_W'(bitCount + 1'b1);
        end
    end

    // Shift in on sample, shift out on request
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rxByte <= `FE_BYTE_RESET;
            txShift <= `FE_TX_RESET;
        end else begin
            if (sampleEn) begin
                rxByte <= {rxByte[6:0], bitIn};
            end
            if (loadEn) begin
                txShift <= loadByte;
            end else if (shiftEn) begin
                txShift <= {txShift[6:0], 1'b1};
            end
        end
    end

    assign txBit = txShift[7];

endmodule : fe_bit_shifter

// ---- fe_master_model.sv ----
/* Behavioural two-wire bus master: makes the serial clock and data.
   Assumes the device pulls data low while sdaOe is high; pull-up otherwise. */
`timescale 1ns/1ps
module fe_master_model (
    input wire logic clock, // System clock
    input wire logic sdaOe, // Device pull-down enable
    output logic scl, // Serial clock, high between frames
    output logic sda // Resolved data wire
);
    logic sdaM;
    // Wired-and data line with pull-up
    assign sda = sdaOe ? 1'b0 : sdaM;
    initial begin
        scl = 1'b1;
        sdaM = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clock);
    endtask : w
    // One bit: data moves while clock low, sampled late in high phase
    task automatic bitx(input logic b, output logic seen);
        w(2);
        sdaM <= b;
        w(3);
        scl <= 1'b1;
        w(4);
        @(negedge clock);
        seen = sda;
        @(posedge clock);
        scl <= 1'b0;
    endtask : bitx
    // Start or repeated start
    task automatic start();
        w(2);
        sdaM <= 1'b1;
        w(3);
        scl <= 1'b1;
        w(5);
        sdaM <= 1'b0;
        w(5);
        scl <= 1'b0;
    endtask : start
    // Stop, both wires left high
    task automatic stop();
        w(2);
        sdaM <= 1'b0;
        w(3);
        scl <= 1'b1;
        w(5);
        sdaM <= 1'b1;
        w(5);
    endtask : stop
    // Eight bits MSB first, ninth bit released or acked
    task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] got, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], got[i]);
        bitx(ackIn, ack);
    endtask : xfer
endmodule : fe_master_model

// ---- tb.sv ----
/* Testbench of the two-wire slave front end: APB tasks and master frames.
   Assumes the master model and the design's default type code. */
`timescale 1ns/1ps
`include "fe_cfg.svh"
module tb import fe_pkg::*; ;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, scl, sda, sdaOut, sdaOe, rxStrobe, rxWriteEn, ack, err;
    logic [2:0] strap = 3'b101;
    logic wp = 1'b0;
    logic [7:0] rxByte, got;
    int badCount = 0, nTests = 0, cycles = 0, strobeCnt = 0, writeCnt = 0;
    localparam logic [3:0] TC = `FE_TYPE_CODE_DEFAULT;
    always #4 clock = ~clock;
    i2c_slave_addr_frontend dut (.clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .strapSelBit0(strap[0]), .strapSelBit1(strap[1]),
        .strapSelBit2(strap[2]), .wpIn(wp), .rxByteOut(rxByte), .rxStrobe(rxStrobe), .rxWriteEn(rxWriteEn));
    fe_master_model m (.clock(clock), .sdaOe(sdaOe), .scl(scl), .sda(sda));
    task automatic completeRun();
        if (badCount == 0 && nTests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : completeRun
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        nTests++;
        if (g !== e) begin
            badCount++;
            $display("BAD %0t %s", $time, s);
        end
    endtask : chk
    // Byte strobes, timeout, open-drain data
    always @(posedge clock) begin
        cycles <= cycles + 1;
        strobeCnt <= strobeCnt + int'(rxStrobe === 1'b1);
        writeCnt <= writeCnt + int'(rxWriteEn === 1'b1);
        if (rst_b) chk(sdaOut, 32'h0, "data driven high");
        if (cycles == 40000) begin
            badCount++;
            completeRun();
        end
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e, input string s);
        apb(a, 1'b0, 32'h0);
        chk(rd & mask, e, s);
    endtask : rdc
    task automatic addr(input logic [3:0] t, input logic [2:0] s, input logic r);
        m.start();
        m.xfer({t, s, r}, 1'b1, got, ack);
    endtask : addr
    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        rdc(`FE_OFS_CTRL, 32'hffffffff, 32'h1, "ctrl reset");
        rdc(`FE_OFS_TXDATA, 32'hffffffff, 32'hff, "tx reset");
        rdc(`FE_OFS_STATUS, 32'h7, ST_IDLE, "not idle");
        rdc(8'h14, 32'hffffffff, 32'h0, "unmapped data");
        chk(err, 32'h1, "unmapped no error");
        apb(`FE_OFS_TXDATA, 1'b1, 32'ha5);
        addr(TC, 3'b101, 1'b0);
        chk(ack, 32'h0, "address not acked");
        m.xfer(8'h3c, 1'b1, got, ack);
        chk(ack, 32'h0, "data not acked");
        m.stop();
        rdc(`FE_OFS_RXDATA, 32'hff, 32'h3c, "byte lost");
        chk(writeCnt, 32'h1, "write not enabled");
        chk(rxByte, 32'h3c, "byte port lost");
        rdc(`FE_OFS_STATUS, 32'h700, 32'h500, "sticky after write");
        rdc(`FE_OFS_STATUS, 32'h7, ST_IDLE, "no standby");
        wp <= 1'b1;
        addr(TC, 3'b101, 1'b0);
        m.xfer(8'h77, 1'b1, got, ack);
        m.stop();
        chk(strobeCnt, 32'h2, "no strobe");
        chk(writeCnt, 32'h1, "protected write stored");
        rdc(`FE_OFS_RXDATA, 32'hff, 32'h3c, "protected byte seen");
        chk(rxByte, 32'h3c, "protected byte on port");
        rdc(`FE_OFS_STATUS, 32'h71f, 32'h710, "blocked flag");
        apb(`FE_OFS_STATUS, 1'b1, 32'h700);
        rdc(`FE_OFS_STATUS, 32'h700, 32'h0, "sticky not cleared");
        addr(TC, 3'b101, 1'b0);
        addr(TC, 3'b101, 1'b1);
        chk(ack, 32'h0, "read not acked");
        m.xfer(8'hff, 1'b0, got, ack);
        chk(got, 32'ha5, "first read byte");
        m.xfer(8'hff, 1'b1, got, ack);
        chk(got, 32'ha5, "second read byte");
        repeat (8) @(posedge clock);
        chk(sdaOe, 32'h0, "bus held after nack");
        m.stop();
        wp <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            addr(TC, 3'b101 ^ (3'b001 << k), 1'b0);
            chk(ack, 32'h1, "select mismatch acked");
            m.stop();
        end
        addr(TC ^ 4'h8, 3'b101, 1'b0);
        chk(ack, 32'h1, "type mismatch acked");
        m.xfer(8'h11, 1'b1, got, ack);
        chk(strobeCnt, 32'h2, "standby took byte");
        rdc(`FE_OFS_ADDRWORD, 32'hff, {24'h0, TC ^ 4'h8, 3'b101, 1'b0}, "address word");
        m.stop();
        m.start();
        for (int i = 3; i >= 0; i--) m.bitx(TC[i], ack);
        m.stop();
        strap <= 3'b000;
        addr(TC, 3'b000, 1'b0);
        chk(ack, 32'h0, "no recovery after abort");
        m.stop();
        apb(`FE_OFS_CTRL, 1'b1, 32'h0);
        addr(TC, 3'b000, 1'b0);
        chk(ack, 32'h1, "disabled acked");
        m.stop();
        completeRun();
    end
endmodule : tb
